// ==== rtl/soft_serial_pkg.sv ====
// Package: constants, register map and carrier types of the software-style serial port
package soft_serial_pkg;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int unsigned CLK_HZ_INT    = 200_000_000;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned US_NS         = 1000;
  localparam int unsigned MS_NS         = 1_000_000;
  localparam int unsigned US_CYC        = US_NS / CLK_PERIOD_NS;
  localparam int unsigned MS_CYC        = MS_NS / CLK_PERIOD_NS;
  localparam logic [28:0] CLK_HZ        = 29'(CLK_HZ_INT);
  localparam logic [7:0]  US_PRE_LAST   = 8'(US_CYC - 1);
  localparam logic [3:0]  OS_LAST       = 4'hf;
  localparam logic [3:0]  OS_HALF_LAST  = 4'h7;
  localparam logic [2:0]  BIT_LAST      = 3'h7;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [31:0] OFF_CTRL   = 32'h0000_0000;
  localparam logic [31:0] OFF_BAUD   = 32'h0000_0004;
  localparam logic [31:0] OFF_GAP    = 32'h0000_0008;
  localparam logic [31:0] OFF_LIMIT  = 32'h0000_000c;
  localparam logic [31:0] OFF_TXDATA = 32'h0000_0010;
  localparam logic [31:0] OFF_RXDATA = 32'h0000_0014;
  localparam logic [31:0] OFF_STATUS = 32'h0000_0018;
  localparam logic [31:0] OFF_MASK   = 32'h0000_001c;
  localparam logic [31:0] OFF_STATE  = 32'h0000_0020;

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int unsigned CTRL_TX_POL  = 0;
  localparam int unsigned CTRL_RX_POL  = 1;
  localparam int unsigned CTRL_TOUT_EN = 2;
  localparam int unsigned CTRL_RX_ARM  = 3;
  localparam int unsigned EV_TX_DONE   = 0;
  localparam int unsigned EV_RX_DONE   = 1;
  localparam int unsigned EV_RX_TOUT   = 2;
  localparam int unsigned EV_RX_FRAME  = 3;
  localparam logic        TX_POL_RST   = 1'b1;
  localparam logic        RX_POL_RST   = 1'b1;
  localparam logic        TOUT_EN_RST  = 1'b0;
  localparam logic [15:0] BAUD_RST     = 16'd9600;
  localparam logic [15:0] GAP_RST      = 16'h0000;
  localparam logic [15:0] LIMIT_RST    = 16'd10000;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    TX_IDLE  = 3'h0,
    TX_START = 3'h1,
    TX_DATA  = 3'h2,
    TX_STOP  = 3'h3,
    TX_GAP   = 3'h4
  } tx_state_e;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'h0,
    RX_WAIT  = 2'h1,
    RX_START = 2'h2,
    RX_DATA  = 2'h3
  } rx_state_e;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } axil_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_s;

  typedef struct packed {
    logic tout_en;
    logic rx_pol;
    logic tx_pol;
  } ctrl_s;

endpackage : soft_serial_pkg

// ==== rtl/soft_serial_tx_rx.sv ====
// Module: pin-level serial transmitter and receiver with an AXI4-Lite register file
// Behaviour
// - Transmit polarity selectable, one is inverted, default inverted
// - Receive polarity selectable separately, default inverted
// - One baud setting 0..65535 for both, default 9600
// - Standard rates 300 to 19200 are generated
// - Fast clock reaches at least 38400 baud
// - Idle gap 0..65535 us after each character
// - Start wait counts milliseconds, expiry flags timeout
// - Timeout disabled means waiting forever
// - Start wait limit defaults to 10000 ms
`timescale 1ns/1ps
`default_nettype none

module soft_serial_tx_rx #(
  parameter int unsigned MS_CYCLES = soft_serial_pkg::MS_CYC
) (
  // Clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // Register bus
  input  wire soft_serial_pkg::axil_req_s  axil_req,
  output var  soft_serial_pkg::axil_rsp_s  axil_rsp,
  // Serial pins
  output logic                             tx_line_pin,
  input  wire logic                        rx_line_pin,
  // Interrupt
  output logic                             irq
);

  localparam logic [17:0] MS_PRE_LAST = 18'(MS_CYCLES - 1);
  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    soft_serial_pkg::axil_rsp_s rsp;
    logic                       aw_have;
    logic [31:0]                aw_addr;
    logic                       w_have;
    logic [31:0]                w_data;
    logic [3:0]                 w_strb;
    soft_serial_pkg::ctrl_s     ctrl;
    logic [15:0]                baud;
    logic [15:0]                gap_us;
    logic [15:0]                limit_ms;
    logic [3:0]                 status;
    logic [3:0]                 mask;
    logic                       irq;
    logic [27:0]                acc;
    logic                       tick;
    soft_serial_pkg::tx_state_e tx_st;
    logic [7:0]                 tx_sh;
    logic [3:0]                 tx_os;
    logic [2:0]                 tx_bit;
    logic [7:0]                 us_pre;
    logic [15:0]                gap_cnt;
    logic                       tx_line;
    logic                       rx_s1;
    logic                       rx_s2;
    soft_serial_pkg::rx_state_e rx_st;
    logic [7:0]                 rx_sh;
    logic [3:0]                 rx_os;
    logic [2:0]                 rx_bit;
    logic                       rx_stop;
    logic [17:0]                ms_pre;
    logic [15:0]                ms_cnt;
    logic [7:0]                 rx_data;
  } state_s;

  state_s      st;
  state_s      n;
  logic [3:0]  clr;
  logic [3:0]  set;
  logic        tx_load;
  logic        rx_arm;
  logic        rxn;
  logic        lvl;
  logic [28:0] sum;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (d & m);
  endfunction : wmerge

  function automatic logic mapped(input logic [31:0] a);
    return (a[1:0] == 2'h0) && (a <= soft_serial_pkg::OFF_STATE);
  endfunction : mapped
  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    n       = st;
    clr     = 4'h0;
    set     = 4'h0;
    tx_load = 1'b0;
    rx_arm  = 1'b0;
    lvl     = 1'b1;
    // Register bus: address and data taken in either order
    if (axil_req.awvalid && st.rsp.awready) begin
      n.aw_have = 1'b1;
      n.aw_addr = axil_req.awaddr;
    end
    if (axil_req.wvalid && st.rsp.wready) begin
      n.w_have = 1'b1;
      n.w_data = axil_req.wdata;
      n.w_strb = axil_req.wstrb;
    end
    if (st.rsp.bvalid && axil_req.bready) begin
      n.rsp.bvalid = 1'b0;
    end
    if (st.aw_have && st.w_have && !st.rsp.bvalid) begin
      n.aw_have    = 1'b0;
      n.w_have     = 1'b0;
      n.rsp.bvalid = 1'b1;
      n.rsp.bresp  = mapped(st.aw_addr) ? soft_serial_pkg::RESP_OKAY
                                        : soft_serial_pkg::RESP_SLVERR;
      if (st.aw_addr == soft_serial_pkg::OFF_CTRL) begin
        n.ctrl = 3'(wmerge({29'h0, st.ctrl}, st.w_data, st.w_strb));
        rx_arm = st.w_strb[0] && st.w_data[soft_serial_pkg::CTRL_RX_ARM];
      end else if (st.aw_addr == soft_serial_pkg::OFF_BAUD) begin
        n.baud = 16'(wmerge({16'h0, st.baud}, st.w_data, st.w_strb));
      end else if (st.aw_addr == soft_serial_pkg::OFF_GAP) begin
        n.gap_us = 16'(wmerge({16'h0, st.gap_us}, st.w_data, st.w_strb));
      end else if (st.aw_addr == soft_serial_pkg::OFF_LIMIT) begin
        n.limit_ms = 16'(wmerge({16'h0, st.limit_ms}, st.w_data, st.w_strb));
      end else if (st.aw_addr == soft_serial_pkg::OFF_TXDATA) begin
        tx_load = st.w_strb[0];
      end else if (st.aw_addr == soft_serial_pkg::OFF_STATUS) begin
        clr = st.w_strb[0] ? st.w_data[3:0] : 4'h0;
      end else if (st.aw_addr == soft_serial_pkg::OFF_MASK) begin
        n.mask = 4'(wmerge({28'h0, st.mask}, st.w_data, st.w_strb));
      end
    end
    if (st.rsp.rvalid && axil_req.rready) begin
      n.rsp.rvalid = 1'b0;
    end
    if (axil_req.arvalid && st.rsp.arready) begin
      n.rsp.rvalid = 1'b1;
      n.rsp.rresp  = mapped(axil_req.araddr) ? soft_serial_pkg::RESP_OKAY
                                             : soft_serial_pkg::RESP_SLVERR;
      n.rsp.rdata  = 32'h0;
      if (axil_req.araddr == soft_serial_pkg::OFF_CTRL) begin
        n.rsp.rdata = {29'h0, st.ctrl};
      end else if (axil_req.araddr == soft_serial_pkg::OFF_BAUD) begin
        n.rsp.rdata = {16'h0, st.baud};
      end else if (axil_req.araddr == soft_serial_pkg::OFF_GAP) begin
        n.rsp.rdata = {16'h0, st.gap_us};
      end else if (axil_req.araddr == soft_serial_pkg::OFF_LIMIT) begin
        n.rsp.rdata = {16'h0, st.limit_ms};
      end else if (axil_req.araddr == soft_serial_pkg::OFF_RXDATA) begin
        n.rsp.rdata = {24'h0, st.rx_data};
      end else if (axil_req.araddr == soft_serial_pkg::OFF_STATUS) begin
        n.rsp.rdata = {28'h0, st.status};
      end else if (axil_req.araddr == soft_serial_pkg::OFF_MASK) begin
        n.rsp.rdata = {28'h0, st.mask};
      end else if (axil_req.araddr == soft_serial_pkg::OFF_STATE) begin
        n.rsp.rdata = {29'h0, st.rx_st != soft_serial_pkg::RX_IDLE && st.rx_st !=
                       soft_serial_pkg::RX_WAIT, st.rx_st == soft_serial_pkg::RX_WAIT,
                       st.tx_st != soft_serial_pkg::TX_IDLE};
      end
    end

    // ------------------------------------------------------------------
    // Oversampling tick at sixteen times the baud rate
    // ------------------------------------------------------------------
    // A phase accumulator avoids a divider; rate error stays below one clock
    sum    = {1'b0, st.acc} + {9'h0, st.baud, 4'h0};
    n.tick = sum >= soft_serial_pkg::CLK_HZ;
    n.acc  = n.tick ? 28'(sum - soft_serial_pkg::CLK_HZ) : sum[27:0];

    // ------------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------------
    n.tx_os = st.tick ? st.tx_os + 4'h1 : st.tx_os;
    case (st.tx_st)
      soft_serial_pkg::TX_IDLE: begin
        if (tx_load) begin
          n.tx_sh = st.w_data[7:0];
          n.tx_os = 4'h0;
          n.tx_st = soft_serial_pkg::TX_START;
        end
      end
      soft_serial_pkg::TX_START: begin
        if (st.tick && st.tx_os == soft_serial_pkg::OS_LAST) begin
          n.tx_bit = 3'h0;
          n.tx_st  = soft_serial_pkg::TX_DATA;
        end
      end
      soft_serial_pkg::TX_DATA: begin
        if (st.tick && st.tx_os == soft_serial_pkg::OS_LAST) begin
          n.tx_sh  = {1'b0, st.tx_sh[7:1]};
          n.tx_bit = st.tx_bit + 3'h1;
          if (st.tx_bit == soft_serial_pkg::BIT_LAST) begin
            n.tx_st = soft_serial_pkg::TX_STOP;
          end
        end
      end
      soft_serial_pkg::TX_STOP: begin
        if (st.tick && st.tx_os == soft_serial_pkg::OS_LAST) begin
          n.us_pre  = 8'h0;
          n.gap_cnt = 16'h0;
          if (st.gap_us == 16'h0) begin
            n.tx_st = soft_serial_pkg::TX_IDLE;
            set[soft_serial_pkg::EV_TX_DONE] = 1'b1;
          end else begin
            n.tx_st = soft_serial_pkg::TX_GAP;
          end
        end
      end
      default: begin
        // Greater-or-equal so a gap_us lowered mid-gap cannot strand the gap
        n.us_pre = st.us_pre == soft_serial_pkg::US_PRE_LAST ? 8'h0 : st.us_pre + 8'h1;
        if (st.us_pre == soft_serial_pkg::US_PRE_LAST) begin
          n.gap_cnt = st.gap_cnt + 16'h1;
          if (n.gap_cnt >= st.gap_us) begin
            n.tx_st = soft_serial_pkg::TX_IDLE;
            set[soft_serial_pkg::EV_TX_DONE] = 1'b1;
          end
        end
      end
    endcase
    case (n.tx_st)
      soft_serial_pkg::TX_START: lvl = 1'b0;
      soft_serial_pkg::TX_DATA:  lvl = n.tx_sh[0];
      default:                   lvl = 1'b1;
    endcase
    n.tx_line = lvl ^ n.ctrl.tx_pol;

    // ------------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------------
    n.rx_s1 = rx_line_pin;
    n.rx_s2 = st.rx_s1;
    rxn     = st.rx_s2 ^ st.ctrl.rx_pol;
    n.rx_os = st.tick ? st.rx_os + 4'h1 : st.rx_os;
    case (st.rx_st)
      soft_serial_pkg::RX_IDLE: begin
        if (rx_arm) begin
          n.ms_pre = 18'h0;
          n.ms_cnt = 16'h0;
          n.rx_st  = soft_serial_pkg::RX_WAIT;
        end
      end
      soft_serial_pkg::RX_WAIT: begin
        n.ms_pre = st.ms_pre == MS_PRE_LAST ? 18'h0 : st.ms_pre + 18'h1;
        if (st.ms_pre == MS_PRE_LAST) begin
          n.ms_cnt = st.ms_cnt + 16'h1;
        end
        if (!rxn) begin
          n.rx_os = 4'h0;
          n.rx_st = soft_serial_pkg::RX_START;
        end else if (st.ctrl.tout_en && st.ms_cnt >= st.limit_ms) begin
          n.rx_st = soft_serial_pkg::RX_IDLE;
          set[soft_serial_pkg::EV_RX_TOUT] = 1'b1;
        end
      end
      soft_serial_pkg::RX_START: begin
        if (st.tick && st.rx_os == soft_serial_pkg::OS_HALF_LAST) begin
          n.rx_os  = 4'h0;
          n.rx_bit = 3'h0;
          // A start shorter than half a bit is a glitch: keep waiting
          n.rx_st  = rxn ? soft_serial_pkg::RX_WAIT : soft_serial_pkg::RX_DATA;
        end
      end
      default: begin
        if (st.tick && st.rx_os == soft_serial_pkg::OS_LAST && st.rx_stop) begin
          n.rx_stop = 1'b0;
          n.rx_data = st.rx_sh;
          n.rx_st   = soft_serial_pkg::RX_IDLE;
          set[soft_serial_pkg::EV_RX_DONE]  = 1'b1;
          set[soft_serial_pkg::EV_RX_FRAME] = !rxn;
        end else if (st.tick && st.rx_os == soft_serial_pkg::OS_LAST) begin
          n.rx_bit  = st.rx_bit + 3'h1;
          n.rx_stop = st.rx_bit == soft_serial_pkg::BIT_LAST;
          n.rx_sh   = {rxn, st.rx_sh[7:1]};
        end
      end
    endcase
    n.status = (st.status & ~clr) | set;
    n.irq    = |(n.status & n.mask);
    n.rsp.arready = !n.rsp.rvalid;
    n.rsp.awready = !n.aw_have && !n.rsp.bvalid;
    n.rsp.wready  = !n.w_have && !n.rsp.bvalid;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '{ctrl: '{tout_en: soft_serial_pkg::TOUT_EN_RST,
                      rx_pol: soft_serial_pkg::RX_POL_RST,
                      tx_pol: soft_serial_pkg::TX_POL_RST},
              baud: soft_serial_pkg::BAUD_RST,
              gap_us: soft_serial_pkg::GAP_RST,
              limit_ms: soft_serial_pkg::LIMIT_RST,
              tx_st: soft_serial_pkg::TX_IDLE,
              rx_st: soft_serial_pkg::RX_IDLE,
              default: '0};
    end else begin
      st <= n;
    end
  end
  assign axil_rsp    = st.rsp;
  assign tx_line_pin = st.tx_line;
  assign irq         = st.irq;
  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  chk_tx_pol_default: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(!aresetn) |-> st.ctrl.tx_pol && !tx_line_pin) else $error("tx polarity not inverted");
  chk_rx_pol_default: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(!aresetn) |-> st.ctrl.rx_pol) else $error("rx polarity not inverted");
  chk_baud_default: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(!aresetn) |-> st.baud == 16'd9600) else $error("baud default wrong");
  chk_tick_cause: assert property (@(posedge aclk) disable iff (!aresetn)
    st.tick |-> $past(st.baud) != 16'h0) else $error("tick without baud");
  chk_acc_range: assert property (@(posedge aclk) disable iff (!aresetn)
    {1'b0, st.acc} < soft_serial_pkg::CLK_HZ) else $error("accumulator overrun");
  chk_gap_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    st.tx_st == soft_serial_pkg::TX_STOP ##1 st.tx_st == soft_serial_pkg::TX_GAP
    |-> st.gap_us != 16'h0 && st.gap_cnt == 16'h0) else $error("gap entered wrongly");
  chk_timeout_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    st.rx_st == soft_serial_pkg::RX_WAIT && rxn && st.ctrl.tout_en &&
    st.ms_cnt >= st.limit_ms |=> st.rx_st == soft_serial_pkg::RX_IDLE &&
    st.status[soft_serial_pkg::EV_RX_TOUT]) else $error("timeout not flagged");
  chk_wait_forever: assert property (@(posedge aclk) disable iff (!aresetn)
    st.rx_st == soft_serial_pkg::RX_WAIT && !st.ctrl.tout_en && rxn
    |=> st.rx_st == soft_serial_pkg::RX_WAIT) else $error("wait abandoned");
  chk_limit_default: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(!aresetn) |-> st.limit_ms == 16'd10000) else $error("limit default wrong");
  chk_start_level: assert property (@(posedge aclk) disable iff (!aresetn)
    st.tx_st == soft_serial_pkg::TX_START |-> tx_line_pin == st.ctrl.tx_pol)
    else $error("start bit level wrong");
  chk_mid_sample: assert property (@(posedge aclk) disable iff (!aresetn)
    st.rx_st == soft_serial_pkg::RX_DATA && st.tick && st.rx_os == 4'hf && !st.rx_stop
    |=> st.rx_sh[7] == $past(rxn)) else $error("bit not sampled");
endmodule : soft_serial_tx_rx
`default_nettype wire

// ==== test/serial_partner.sv ====
// Far-side serial terminal model: drives the receive pin, decodes the transmit pin
`timescale 1ns/1ps
`default_nettype none

module serial_partner (
  // Line settings
  input  wire logic        tx_pol,
  input  wire logic        rx_pol,
  input  wire logic [15:0] baud,
  input  wire logic        listen,
  // Serial pins
  input  wire logic        tx_line_pin,
  output logic             rx_line_pin
);
  // ------------------------------------------------------------------
  // Line state
  // ------------------------------------------------------------------
  logic       drv_norm = 1'b1;
  logic [7:0] got_q[$];

  // Always driven, so the receive pin never floats between frames
  assign rx_line_pin = drv_norm ^ rx_pol;

  // ------------------------------------------------------------------
  // Sender, lead time lets the bench answer promptly or slowly
  // ------------------------------------------------------------------
  task automatic send(input logic [7:0] d, input int unsigned lead_ns);
    real b;
    b = 1.0e9 / real'(baud);
    #(lead_ns);
    drv_norm = 1'b0;
    #(b);
    for (int i = 0; i < 8; i++) begin
      drv_norm = d[i];
      #(b);
    end
    drv_norm = 1'b1;
    #(b);
  endtask : send

  // ------------------------------------------------------------------
  // Decoder, samples mid-bit; a bad stop bit drops the character
  // ------------------------------------------------------------------
  initial begin : decode
    logic [7:0] sh;
    real        b;
    forever begin
      wait (listen === 1'b1 && (tx_line_pin ^ tx_pol) === 1'b0);
      b = 1.0e9 / real'(baud);
      #(b / 2.0);
      for (int i = 0; i < 8; i++) begin
        #(b);
        sh[i] = tx_line_pin ^ tx_pol;
      end
      #(b);
      if ((tx_line_pin ^ tx_pol) === 1'b1) got_q.push_back(sh);
      wait ((tx_line_pin ^ tx_pol) === 1'b1);
    end
  end
endmodule : serial_partner
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench: registers, transmit, receive, timeout and interrupt
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  localparam int unsigned MS_SIM = 20;
  localparam logic [31:0] RA [5] = '{32'h0, 32'h4, 32'h8, 32'hc, 32'h1c};
  localparam logic [31:0] RV [5] = '{32'h3, 32'h2580, 32'h0, 32'h2710, 32'h0};
  logic                       aclk;
  logic                       aresetn;
  soft_serial_pkg::axil_req_s req;
  soft_serial_pkg::axil_rsp_s rsp;
  logic                       tx_line_pin;
  logic                       rx_line_pin;
  logic                       irq;
  logic                       p_tx_pol;
  logic                       p_rx_pol;
  logic [15:0]                p_baud;
  logic                       listen;
  int                         n_fail;
  int                         checks;
  logic [7:0]                 exp_q[$];
  logic [31:0]                rd;
  logic [1:0]                 resp;
  logic [7:0]                 b;
  int unsigned                gap;
  int                         n;

  soft_serial_tx_rx #(.MS_CYCLES(MS_SIM)) i_soft_serial_tx_rx (
    .aclk(aclk), .aresetn(aresetn), .axil_req(req), .axil_rsp(rsp),
    .tx_line_pin(tx_line_pin), .rx_line_pin(rx_line_pin), .irq(irq)
  );

  serial_partner i_serial_partner (
    .tx_pol(p_tx_pol), .rx_pol(p_rx_pol), .baud(p_baud), .listen(listen),
    .tx_line_pin(tx_line_pin), .rx_line_pin(rx_line_pin)
  );

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      k++;
    end while (rsp.bvalid !== 1'b1 && k < 100);
    req.bready <= 1'b0;
    chk({31'h0, rsp.bvalid}, 32'h1);
    chk({30'h0, rsp.bresp}, {30'h0, soft_serial_pkg::RESP_OKAY});
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    k = 0;
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      k++;
    end while (rsp.rvalid !== 1'b1 && k < 100);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
    chk({31'h0, rsp.rvalid}, 32'h1);
  endtask : axi_rd

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  // Two frames at top rate take about 61000 cycles
  initial begin : watchdog
    repeat (95000) @(posedge aclk);
    n_fail++;
    end_of_test();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin : main
    void'($urandom(32'ha71e1c39));
    req = '0;
    aresetn = 1'b0;
    listen = 1'b0;
    p_tx_pol = 1'b1;
    p_rx_pol = 1'b1;
    p_baud = 16'd9600;
    n_fail = 0;
    checks = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({30'h0, tx_line_pin, irq}, 32'h0);
    for (int i = 0; i < 5; i++) begin
      axi_rd(RA[i], rd, resp);
      chk(rd, RV[i]);
    end
    axi_rd(32'h24, rd, resp);
    chk({rd[29:0], resp}, {30'h0, soft_serial_pkg::RESP_SLVERR});
    // Transmit at the top rate with a random gap, default inverted line
    gap = 4 + $urandom_range(4);
    b = 8'($urandom);
    axi_wr(soft_serial_pkg::OFF_BAUD, 32'd65535);
    p_baud <= 16'hffff;
    axi_wr(soft_serial_pkg::OFF_GAP, gap);
    axi_wr(soft_serial_pkg::OFF_MASK, 32'h7);
    exp_q.push_back(b);
    listen <= 1'b1;
    axi_wr(soft_serial_pkg::OFF_TXDATA, {24'h0, b});
    n = 0;
    while (i_serial_partner.got_q.size() == 0 && n < 40000) begin
      @(posedge aclk);
      n++;
    end
    chk({24'h0, i_serial_partner.got_q[0]}, {24'h0, exp_q[0]});
    listen <= 1'b0;
    axi_rd(soft_serial_pkg::OFF_STATUS, rd, resp);
    chk({30'h0, rd[0], irq}, 32'h0);
    n = 0;
    while (irq !== 1'b1 && n < 20000) begin
      @(posedge aclk);
      n++;
    end
    // Half a stop bit, about 1526 cycles at the top rate, runs before the gap
    chk({31'h0, n >= int'(gap * soft_serial_pkg::US_CYC) + 1200}, 32'h1);
    chk({31'h0, n <= int'(gap * soft_serial_pkg::US_CYC) + 1700}, 32'h1);
    axi_rd(soft_serial_pkg::OFF_STATUS, rd, resp);
    chk(rd, 32'h1);
    axi_wr(soft_serial_pkg::OFF_STATUS, 32'h1);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    // True polarity both ways: idle line turns high
    axi_wr(soft_serial_pkg::OFF_CTRL, 32'h0);
    p_tx_pol <= 1'b0;
    p_rx_pol <= 1'b0;
    repeat (3) @(posedge aclk);
    chk({31'h0, tx_line_pin}, 32'h1);
    // Receive with timeout disabled: long wait, then a random character
    axi_wr(soft_serial_pkg::OFF_LIMIT, 32'h1);
    axi_wr(soft_serial_pkg::OFF_CTRL, 32'h8);
    repeat (5 * MS_SIM) @(posedge aclk);
    axi_rd(soft_serial_pkg::OFF_STATE, rd, resp);
    chk(rd & 32'h2, 32'h2);
    axi_rd(soft_serial_pkg::OFF_STATUS, rd, resp);
    chk(rd, 32'h0);
    b = 8'($urandom);
    i_serial_partner.send(b, 100 + $urandom_range(900));
    repeat (20) @(posedge aclk);
    axi_rd(soft_serial_pkg::OFF_RXDATA, rd, resp);
    chk(rd, {24'h0, b});
    axi_rd(soft_serial_pkg::OFF_STATUS, rd, resp);
    chk({rd[30:0], irq}, 32'h5);
    axi_wr(soft_serial_pkg::OFF_STATUS, 32'h2);
    // Timeout of 3 ms must not fire at 2 ms and must fire by 4 ms
    axi_wr(soft_serial_pkg::OFF_LIMIT, 32'h3);
    axi_wr(soft_serial_pkg::OFF_CTRL, 32'hc);
    repeat (2 * MS_SIM) @(posedge aclk);
    axi_rd(soft_serial_pkg::OFF_STATUS, rd, resp);
    chk(rd, 32'h0);
    n = 0;
    while (irq !== 1'b1 && n < 2 * MS_SIM) begin
      @(posedge aclk);
      n++;
    end
    axi_rd(soft_serial_pkg::OFF_STATUS, rd, resp);
    chk({rd[30:0], irq}, 32'h9);
    axi_wr(soft_serial_pkg::OFF_MASK, 32'h3);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    axi_wr(soft_serial_pkg::OFF_STATUS, 32'h4);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
